// ---- logic/cpu_bus_control.v ----
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`include "cpu_bus_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module cpu_bus_control (
    input wire aclk,
    input wire aresetn,
    input wire [4:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [4:0] araddr,
    input wire arvalid,
    output wire arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    input wire [7:0] ad_in,
    output reg [7:0] ad_out,
    output reg ad_oe,
    output reg [7:0] addr_hi_out,
    output reg addr_hi_oe,
    output reg [3:0] addr_stat_out,
    output reg addr_stat_oe,
    output reg rd_n_out,
    output reg rd_n_oe,
    output reg mem_io_select_out,
    output reg mem_io_select_oe,
    output reg cycle_status_bit_2_out,
    output reg cycle_status_bit_2_oe,
    output reg hold_ack,
    input wire ready,
    input wire maskable_irq,
    input wire nmi_request,
    input wire test_gate_n,
    input wire cpu_reset,
    input wire hold_request,
    input wire bus_mode_select
);
    localparam ST_IDLE = 3'h0;
    localparam ST_T1 = 3'h1;
    localparam ST_T2 = 3'h2;
    localparam ST_T3 = 3'h3;
    localparam ST_TW = 3'h4;
    localparam ST_T4 = 3'h5;
    localparam ST_HOLD = 3'h6;

    wire s_irq;
    wire s_nmi;
    wire s_test_n;
    reg nmi_d;

    reg [2:0] state;
    reg phase;
    reg ie;
    reg io_sel;
    reg [1:0] seg_code;
    reg [19:0] addr;
    reg [7:0] vect_type;
    reg [31:0] handler;
    reg handler_valid;
    reg start_req;
    reg wtest;
    reg irq_pend;
    reg nmi_pend;
    reg fetching;
    reg [7:0] fetch_type;
    reg [1:0] fetch_cnt;
    reg [7:0] rdata_cap;
    reg [19:0] cyc_addr;
    reg cyc_io;
    reg [1:0] cyc_seg;

    reg aw_got;
    reg w_got;
    reg [4:0] aw_q;
    reg [31:0] wd_q;
    reg [3:0] ws_q;
    wire wr_en;
    wire [31:0] ctrl_w;
    wire [31:0] addr_w;
    wire [31:0] vect_w;
    wire busy;
    reg [31:0] rd_mux;
    reg rd_err;

    reg [7:0] next_ad_out;
    reg next_ad_oe;
    reg next_addr_hi_oe;
    reg [3:0] next_addr_stat_out;
    reg next_addr_stat_oe;
    reg next_rd_n;
    reg next_rd_oe;
    reg next_sel_oe;
    reg next_s2_oe;

    // maskable request, non-maskable request and test gate
    sync_bits #(.W(3)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({test_gate_n, nmi_request, maskable_irq}),
        .sync_out({s_test_n, s_nmi, s_irq})
    );

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1)
                if (strb[k])
                    merge[8*k +: 8] = nw[8*k +: 8];
        end
    endfunction

    // axi4-lite write path: address and data taken in either order
    assign awready = ~aw_got & ~bvalid;
    assign wready = ~w_got & ~bvalid;
    assign wr_en = aw_got & w_got & ~bvalid;
    assign ctrl_w = merge({22'h0, seg_code, 5'h0, io_sel, 1'b0, ie}, wd_q, ws_q);
    assign addr_w = merge({12'h0, addr}, wd_q, ws_q);
    assign vect_w = merge({24'h0, vect_type}, wd_q, ws_q);
    assign arready = ~rvalid;
    assign busy = start_req | fetching | (state != ST_IDLE && state != ST_HOLD);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_q <= 5'h00;
            wd_q <= 32'h0;
            ws_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= `RESP_OKAY;
            rdata <= 32'h0;
        end else begin
            if (awvalid && awready) begin
                aw_got <= 1'b1;
                aw_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_got <= 1'b1;
                wd_q <= wdata;
                ws_q <= wstrb;
            end
            if (wr_en) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (aw_q[4:2] > 3'h4) ? `RESP_SLVERR : `RESP_OKAY;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata <= rd_mux;
                rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    always @* begin
        rd_mux = 32'h0;
        rd_err = 1'b0;
        case ({araddr[4:2], 2'b00})
            `OFF_CTRL: rd_mux = {22'h0, seg_code, 5'h0, io_sel, 1'b0, ie};
            `OFF_ADDR: rd_mux = {12'h0, addr};
            `OFF_STAT: begin
                rd_mux[`SB_BUSY] = busy;
                rd_mux[`SB_WTEST] = wtest;
                rd_mux[`SB_IRQ] = irq_pend;
                rd_mux[`SB_NMI] = nmi_pend;
                rd_mux[`SB_HOLD] = hold_ack;
                rd_mux[`SB_MODE] = bus_mode_select;
                rd_mux[`SB_HVALID] = handler_valid;
                rd_mux[`SB_RESET] = cpu_reset;
                rd_mux[`SB_DATA +: 8] = rdata_cap;
                rd_mux[`SB_STATE +: 3] = state;
            end
            `OFF_VECT: rd_mux = {24'h0, vect_type};
            `OFF_HNDL: rd_mux = handler;
            default: rd_err = 1'b1;
        endcase
    end

    // bus state machine; one T state lasts two aclk cycles (phase is the divider)
    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            phase <= 1'b0;
            nmi_d <= 1'b0;
            ie <= `RST_IE;
            io_sel <= 1'b0;
            seg_code <= `RST_SEG;
            addr <= 20'h0;
            vect_type <= `RST_VECT;
            handler <= 32'h0;
            handler_valid <= 1'b0;
            start_req <= 1'b0;
            wtest <= 1'b0;
            irq_pend <= 1'b0;
            nmi_pend <= 1'b0;
            fetching <= 1'b0;
            fetch_type <= 8'h00;
            fetch_cnt <= 2'b00;
            rdata_cap <= 8'h00;
            cyc_addr <= 20'h0;
            cyc_io <= 1'b0;
            cyc_seg <= `RST_SEG;
        end else begin
            phase <= ~phase;
            nmi_d <= s_nmi;
            if (wr_en && {aw_q[4:2], 2'b00} == `OFF_CTRL) begin
                ie <= ctrl_w[`CB_IE];
                io_sel <= ctrl_w[`CB_IO];
                seg_code <= ctrl_w[`CB_SEG +: 2];
            end
            if (wr_en && {aw_q[4:2], 2'b00} == `OFF_ADDR)
                addr <= addr_w[19:0];
            if (wr_en && {aw_q[4:2], 2'b00} == `OFF_VECT)
                vect_type <= vect_w[7:0];
            if (wtest && !s_test_n)
                wtest <= 1'b0;
            if (phase) begin
                case (state)
                    ST_IDLE: begin
                        if (hold_request) begin
                            state <= ST_HOLD;
                        end else if (fetching) begin
                            state <= ST_T1;
                            cyc_addr <= {10'h000, fetch_type, fetch_cnt};
                        end else if (nmi_pend) begin
                            nmi_pend <= 1'b0;
                            fetching <= 1'b1;
                            fetch_type <= `NMI_TYPE;
                        end else if (irq_pend && ie) begin
                            irq_pend <= 1'b0;
                            fetching <= 1'b1;
                            fetch_type <= vect_type;
                        end else if (start_req && !wtest) begin
                            // a started read waits behind wait-for-test
                            start_req <= 1'b0;
                            state <= ST_T1;
                            cyc_addr <= addr;
                            cyc_io <= io_sel;
                            cyc_seg <= seg_code;
                        end
                        if (fetching || nmi_pend || (irq_pend && ie)) begin
                            cyc_io <= 1'b0;
                            cyc_seg <= `SEG_FETCH;
                        end
                    end
                    ST_T1: state <= ST_T2;
                    ST_T2: state <= ST_T3;
                    ST_T3, ST_TW: begin
                        if (ready) begin
                            state <= ST_T4;
                            if (fetching)
                                handler[8*fetch_cnt +: 8] <= ad_in;
                            else
                                rdata_cap <= ad_in;
                        end else begin
                            state <= ST_TW;
                        end
                    end
                    ST_T4: begin
                        state <= ST_IDLE;
                        if (fetching) begin
                            fetch_cnt <= fetch_cnt + 2'b01;
                            if (fetch_cnt == 2'b11)
                                fetching <= 1'b0;
                        end
                    end
                    ST_HOLD: begin
                        if (!hold_request)
                            state <= ST_IDLE;
                    end
                    default: state <= ST_IDLE;
                endcase
            end
            // sets follow the state machine clears so a coinciding event is kept; the cpu_reset clears come last and win
            if (wr_en && {aw_q[4:2], 2'b00} == `OFF_CTRL) begin
                if (ctrl_w[`CB_HCLR])
                    handler_valid <= 1'b0;
                if (ctrl_w[`CB_START] && !busy)
                    start_req <= 1'b1;
                if (ctrl_w[`CB_WTEST])
                    wtest <= 1'b1;
                if (ctrl_w[`CB_IEND] && ctrl_w[`CB_IE] && s_irq)
                    irq_pend <= 1'b1;
            end
            if (phase && state == ST_T4 && fetching && fetch_cnt == 2'b11)
                handler_valid <= 1'b1;
            if (s_nmi && !nmi_d)
                nmi_pend <= 1'b1;
            if (cpu_reset) begin
                // abandon at once, not at the next T state boundary
                state <= ST_IDLE;
                fetching <= 1'b0;
                fetch_cnt <= 2'b00;
                start_req <= 1'b0;
                wtest <= 1'b0;
                irq_pend <= 1'b0;
                nmi_pend <= 1'b0;
            end
        end
    end

    // pin values derived from the state, then registered
    always @* begin
        next_ad_out = cyc_addr[7:0];
        next_ad_oe = (state == ST_T1);
        next_addr_hi_oe = (state >= ST_T1 && state <= ST_T4);
        next_addr_stat_oe = next_addr_hi_oe;
        if (state == ST_T1)
            next_addr_stat_out = cyc_io ? 4'h0 : cyc_addr[19:16];
        else
            next_addr_stat_out = {1'b0, ie, cyc_seg};
        // first half of T2 keeps the strobe high while the lines float
        next_rd_n = ~((state == ST_T2 && phase) || state == ST_T3 || state == ST_TW);
        next_rd_oe = (state != ST_HOLD);
        next_sel_oe = bus_mode_select && state != ST_HOLD;
        next_s2_oe = !bus_mode_select && next_addr_hi_oe;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            ad_out <= 8'h00;
            ad_oe <= 1'b0;
            addr_hi_out <= 8'h00;
            addr_hi_oe <= 1'b0;
            addr_stat_out <= 4'h0;
            addr_stat_oe <= 1'b0;
            rd_n_out <= 1'b1;
            rd_n_oe <= 1'b0;
            mem_io_select_out <= 1'b0;
            mem_io_select_oe <= 1'b0;
            cycle_status_bit_2_out <= 1'b1;
            cycle_status_bit_2_oe <= 1'b0;
            hold_ack <= 1'b0;
        end else begin
            ad_out <= next_ad_out;
            ad_oe <= next_ad_oe && !cpu_reset;
            addr_hi_out <= cyc_addr[15:8];
            addr_hi_oe <= next_addr_hi_oe && !cpu_reset;
            addr_stat_out <= next_addr_stat_out;
            addr_stat_oe <= next_addr_stat_oe && !cpu_reset;
            rd_n_out <= next_rd_n || cpu_reset;
            rd_n_oe <= next_rd_oe;
            mem_io_select_out <= cyc_io;
            mem_io_select_oe <= next_sel_oe;
            cycle_status_bit_2_out <= ~cyc_io;
            cycle_status_bit_2_oe <= next_s2_oe && !cpu_reset;
            hold_ack <= (state == ST_HOLD);
        end
    end
endmodule // cpu_bus_control

`default_nettype wire

// ---- logic/cpu_bus_consts.vh ----
`ifndef CPU_BUS_CONSTS_VH
`define CPU_BUS_CONSTS_VH

// register byte offsets (5-bit register space)
`define OFF_CTRL 5'h00
`define OFF_ADDR 5'h04
`define OFF_STAT 5'h08
`define OFF_VECT 5'h0c
`define OFF_HNDL 5'h10

// control register fields
`define CB_IE 0
`define CB_START 1
`define CB_IO 2
`define CB_WTEST 3
`define CB_IEND 4
`define CB_HCLR 5
`define CB_SEG 8

// status register fields
`define SB_BUSY 0
`define SB_WTEST 1
`define SB_IRQ 2
`define SB_NMI 3
`define SB_HOLD 4
`define SB_MODE 5
`define SB_HVALID 6
`define SB_RESET 7
`define SB_DATA 8
`define SB_STATE 16

// reset values
`define RST_IE 1'b0
`define RST_SEG 2'b10
`define RST_VECT 8'h00

// fixed interrupt type of the non-maskable request
`define NMI_TYPE 8'h02
// segment code shown during vector fetches: code or none
`define SEG_FETCH 2'b10

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ---- logic/sync_bits.v ----
`timescale 1ns/1ns
`default_nettype none

module sync_bits #(
    parameter W = 3
) (
    input wire aclk,
    input wire aresetn,
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg stage1;
            reg stage2;
            // stage1 feeds stage2 only
            always @(posedge aclk) begin
                if (!aresetn) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else begin
                    stage1 <= async_in[i];
                    stage2 <= stage1;
                end
            end
            assign sync_out[i] = stage2;
        end
    endgenerate
endmodule // sync_bits

`default_nettype wire

// ---- verif/cpu_bus_checker_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ready,
    input wire logic cpu_reset,
    input wire logic bus_mode_select,
    input wire logic hold_ack,
    input wire logic rd_n_out,
    input wire logic rd_n_oe,
    input wire logic ad_oe,
    input wire logic addr_hi_oe,
    input wire logic [3:0] addr_stat_out,
    input wire logic addr_stat_oe,
    input wire logic mem_io_select_oe,
    input wire logic cycle_status_bit_2_oe
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence rd_active;
        !rd_n_out && rd_n_oe;
    endsequence
    sequence rd_fall;
        $fell(rd_n_out);
    endsequence
    // two stalled samples always cover one sampling point of ready
    sequence stall2;
        (!rd_n_out && !ready) [*2];
    endsequence
    a_rd_keeper: assert property (!rd_n_oe |-> rd_n_out)
        else $error("read strobe released while low");
    a_hold_float: assert property (hold_ack [*2] |-> !ad_oe && !addr_hi_oe && !addr_stat_oe && !rd_n_oe)
        else $error("bus lines driven during hold");
    a_rd_after_float: assert property (rd_active |-> !ad_oe && !$past(ad_oe))
        else $error("read strobe low while address driven");
    a_rd_min_low: assert property (disable iff (!aresetn || cpu_reset) rd_fall |-> !rd_n_out [*3])
        else $error("read strobe low shorter than three cycles");
    a_wait_extend: assert property (disable iff (!aresetn || cpu_reset) stall2 |=> !rd_n_out)
        else $error("read ended while ready low");
    a_stat_top_low: assert property (rd_active |-> addr_hi_oe && addr_stat_oe && addr_stat_out[3] == 1'b0)
        else $error("status lines wrong during transfer");
    a_min_pins: assert property (bus_mode_select [*2] |-> !cycle_status_bit_2_oe)
        else $error("status bit driven in minimum mode");
    a_max_pins: assert property (!bus_mode_select [*2] |-> !mem_io_select_oe)
        else $error("select pin driven in maximum mode");
    a_reset_abort: assert property (cpu_reset [*2] |-> rd_n_out && !addr_stat_oe)
        else $error("bus cycle kept during processor reset");
endmodule // cpu_bus_checker
bind cpu_bus_control cpu_bus_checker chk_u (.*);
`default_nettype wire

// ---- verif/bus_device.sv ----
`timescale 1ns/1ns
`default_nettype none
module bus_device (
    input wire logic aclk,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe,
    input wire logic [7:0] addr_hi_out,
    input wire logic [3:0] addr_stat_out,
    input wire logic rd_n_out,
    input wire logic mem_io_select_out,
    input wire logic cycle_status_bit_2_out,
    input wire logic [3:0] slow,
    output logic [7:0] ad_in,
    output logic ready,
    output logic [19:0] last_addr,
    output logic [7:0] low_len,
    output logic [1:0] last_seg,
    output logic last_sel,
    output logic last_s2
);
    logic [7:0] cnt = 8'h00;
    logic [7:0] last = 8'h00;
    assign ready = rd_n_out | (cnt >= {4'h0, slow});
    // keeper level is not trusted: released lines toggle every cycle
    always @* begin
        if (ad_oe)
            ad_in = ad_out;
        else if (!rd_n_out)
            ad_in = last_addr[7:0] ^ last_addr[15:8] ^ 8'h5a;
        else
            ad_in = ~last;
    end
    always @(posedge aclk) begin
        last <= ad_in;
        if (ad_oe)
            last_addr <= {addr_stat_out, addr_hi_out, ad_out};
        if (!rd_n_out) begin
            cnt <= cnt + 8'h01;
            last_seg <= addr_stat_out[1:0];
            last_sel <= mem_io_select_out;
            last_s2 <= cycle_status_bit_2_out;
        end else if (cnt != 8'h00) begin
            low_len <= cnt;
            cnt <= 8'h00;
        end
    end
endmodule // bus_device
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cpu_bus_consts.vh"
module testbench;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, rdata, s, x;
    logic [3:0] wstrb, addr_stat_out, slow;
    logic [1:0] bresp, rresp, last_seg, r, sg;
    logic ad_oe, addr_hi_oe, addr_stat_oe, rd_n_out, rd_n_oe, hold_ack, io;
    logic mem_io_select_out, mem_io_select_oe, cycle_status_bit_2_out, cycle_status_bit_2_oe, last_sel, last_s2;
    logic ready, maskable_irq, nmi_request, test_gate_n, cpu_reset, hold_request, bus_mode_select;
    logic [7:0] ad_in, ad_out, addr_hi_out, low_len, t;
    logic [19:0] last_addr, a;
    int miscompares = 0;
    int samples_checked = 0;
    int seed = 32'hcd02;
    int d, i;
    cpu_bus_control dut_u (.*);
    bus_device dev_u (.*);
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        final_report;
    end
    task final_report;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        samples_checked++;
        if (v !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, v);
        end
    endtask
    function logic [7:0] mb(input logic [19:0] ad);
        mb = ad[7:0] ^ ad[15:8] ^ 8'h5a;
    endfunction
    function logic [31:0] hv(input logic [7:0] ty);
        hv = {mb({ty, 2'd3}), mb({ty, 2'd2}), mb({ty, 2'd1}), mb({ty, 2'd0})};
    endfunction
    task axw(input logic [4:0] ad, input logic [31:0] dt, output logic [1:0] rs);
        logic ka, kw, v;
        @(posedge aclk);
        awaddr <= ad;
        wdata <= dt;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        v = 1'b0;
        while (!v) begin
            @(negedge aclk);
            ka = awvalid & awready;
            kw = wvalid & wready;
            v = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (ka) awvalid <= 1'b0;
            if (kw) wvalid <= 1'b0;
            if (v) bready <= 1'b0;
        end
    endtask
    task axr(input logic [4:0] ad, output logic [31:0] dt, output logic [1:0] rs);
        logic k, v;
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        v = 1'b0;
        while (!v) begin
            @(negedge aclk);
            k = arvalid & arready;
            v = rvalid;
            dt = rdata;
            rs = rresp;
            @(posedge aclk);
            if (k) arvalid <= 1'b0;
            if (v) rready <= 1'b0;
        end
    endtask
    task poll(input int b, input logic v);
        logic [31:0] q;
        logic [1:0] rr;
        do axr(`OFF_STAT, q, rr); while (q[b] !== v);
    endtask
    task rd_cycle;
        x = $random(seed);
        io = x[20];
        sg = x[22:21];
        a = io ? {4'h0, x[15:0]} : x[19:0];
        d = x[24] ? 0 : 3 + x[26:25];
        slow <= d[3:0];
        bus_mode_select <= x[23];
        axw(`OFF_ADDR, {12'h0, x[19:0]}, r);
        axw(`OFF_CTRL, {22'h0, sg, 5'h0, io, 2'b10}, r);
        poll(`SB_BUSY, 1'b0);
        axr(`OFF_STAT, s, r);
        chk("read_byte", mb(a), s[15:8]);
        chk("cycle_addr", a, last_addr);
        chk("seg_code", sg, last_seg);
        if (bus_mode_select) chk("io_sel", io, last_sel);
        else chk("io_s2", !io, last_s2);
        if (d == 0) chk("rd_len", 3, low_len);
        else chk("rd_len_odd", 1, low_len[0]);
        if (d != 0) chk("rd_len_long", 1, low_len >= 8'd5);
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, maskable_irq, nmi_request} = 8'h00;
        {cpu_reset, hold_request, awaddr, araddr, wdata, slow} = 0;
        {test_gate_n, bus_mode_select, wstrb} = 6'h3f;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axr(`OFF_CTRL, s, r);
        chk("ctrl_rst", 32'h200, s & 32'h301);
        axr(`OFF_VECT, s, r);
        chk("vect_rst", 32'h0, s);
        axr(5'h14, s, r);
        chk("bad_rd", `RESP_SLVERR, r);
        axw(5'h18, 32'hffffffff, r);
        chk("bad_wr", `RESP_SLVERR, r);
        for (i = 0; i < 8; i++) rd_cycle;
        hold_request <= 1'b1;
        while (hold_ack !== 1'b1) @(negedge aclk);
        repeat (3) @(negedge aclk);
        chk("hold_rd_oe", 0, rd_n_oe);
        chk("hold_as_oe", 0, addr_stat_oe);
        @(posedge aclk);
        hold_request <= 1'b0;
        nmi_request <= 1'b1;
        poll(`SB_HVALID, 1'b1);
        axr(`OFF_HNDL, s, r);
        chk("nmi_hndl", hv(`NMI_TYPE), s);
        chk("vec_seg", `SEG_FETCH, last_seg);
        nmi_request <= 1'b0;
        axw(`OFF_CTRL, 32'h220, r);
        x = $random(seed);
        t = x[7:0];
        axw(`OFF_VECT, {24'h0, t}, r);
        maskable_irq <= 1'b1;
        axw(`OFF_CTRL, 32'h210, r);
        repeat (20) @(posedge aclk);
        axr(`OFF_STAT, s, r);
        chk("irq_masked", 0, s[`SB_HVALID]);
        axw(`OFF_CTRL, 32'h211, r);
        poll(`SB_HVALID, 1'b1);
        axr(`OFF_HNDL, s, r);
        chk("irq_hndl", hv(t), s);
        maskable_irq <= 1'b0;
        axw(`OFF_CTRL, 32'h220, r);
        axw(`OFF_CTRL, 32'h208, r);
        repeat (20) @(posedge aclk);
        axr(`OFF_STAT, s, r);
        chk("test_wait", 1, s[`SB_WTEST]);
        test_gate_n <= 1'b0;
        poll(`SB_WTEST, 1'b0);
        test_gate_n <= 1'b1;
        slow <= 4'hf;
        axw(`OFF_CTRL, 32'h202, r);
        while (rd_n_out !== 1'b0) @(negedge aclk);
        @(posedge aclk);
        cpu_reset <= 1'b1;
        axr(`OFF_STAT, s, r);
        chk("rst_flag", 1, s[`SB_RESET]);
        chk("rst_busy", 0, s[`SB_BUSY]);
        repeat (2) @(posedge aclk);
        cpu_reset <= 1'b0;
        axr(`OFF_STAT, s, r);
        chk("rst_state", 0, s[18:16]);
        rd_cycle;
        final_report;
    end
endmodule // testbench
`default_nettype wire
